// ===== rtl/converter_ctrl_defs.vh
// Constants for the converter control register bank: command codes,
// field positions, reset values and slew timing.
// Assumes inclusion by bare name from the design files.
`ifndef CONVERTER_CTRL_DEFS_VH
`define CONVERTER_CTRL_DEFS_VH

`define CMD_VOUT_SLEW_STEP 8'hda
`define CMD_LOW_POWER_CONTROL 8'he5
`define CMD_MISC_FUNCTION_CONTROL 8'hea

`define RST_VOUT_SLEW_STEP 4'h4
`define RST_LOW_POWER_CONTROL 2'h0
`define RST_ADJ_HICCUP_SELECT 1'h0
`define RST_SINK_MODE_DISABLE 1'h0
`define RST_MULTI_PHASE 1'h1

`define SLEW_STEP_MSB 3
`define LP_BUS_BIT 0
`define LP_PIN_BIT 1
`define MISC_ADJ_HICCUP_BIT 10
`define MISC_SINK_DISABLE_BIT 9
`define MISC_MULTI_PHASE_BIT 3

`define CLK_PERIOD_PS 5000
`define SLEW_BASE_PS 20000000
`define SLEW_INC_PS 2500000

`endif

// ===== rtl/vout_slew_stepper.v
// Output-voltage target stepper: moves the applied code one 2 mV step
// per slew period after soft start, and follows the target during it.
// Assumes the soft-start ramp itself is shaped by logic elsewhere.
`timescale 1ns/1ps
module vout_slew_stepper #(
    parameter VW = 12,
    parameter CW = 14,
    parameter BASE_CYCLES = 4000,
    parameter INC_CYCLES = 500
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [3:0] step_code_i,
    input wire soft_start_done_i,
    input wire [VW-1:0] vout_target_i,
    output reg [VW-1:0] vout_applied_o,
    output wire slewing_o
);

    reg [CW-1:0] cnt;

    function [CW-1:0] step_period;
        input [3:0] code;
        begin
            step_period = BASE_CYCLES[CW-1:0] +
                          code * INC_CYCLES[CW-1:0];
        end
    endfunction

    assign slewing_o = soft_start_done_i &&
                       (vout_applied_o != vout_target_i);

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= {CW{1'b0}};
            vout_applied_o <= {VW{1'b0}};
        end else if (!soft_start_done_i) begin
            // The soft-start ramp owns the slope here, so the slew
            // setting has no say and the code simply tracks.
            cnt <= {CW{1'b0}};
            vout_applied_o <= vout_target_i;
        end else if (vout_applied_o == vout_target_i) begin
            cnt <= {CW{1'b0}};
        end else if (cnt >= step_period(step_code_i) - 1'b1) begin
            // Base period plus one increment per code value.
            cnt <= {CW{1'b0}};
            if (vout_applied_o < vout_target_i) begin
                vout_applied_o <= vout_applied_o + 1'b1;
            end else begin
                vout_applied_o <= vout_applied_o - 1'b1;
            end
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule // vout_slew_stepper

// ===== rtl/converter_ctrl_regs.v
// Converter control register bank: slew step, low-power control and
// the misc function control word, with their effects on the power stage.
// Assumes a command-level port from the bus transport on the same clock.
`timescale 1ns/1ps
`include "converter_ctrl_defs.vh"
module converter_ctrl_regs #(
    parameter VW = 12,
    parameter STEP_BASE_CYCLES = `SLEW_BASE_PS / `CLK_PERIOD_PS,
    parameter STEP_INC_CYCLES = `SLEW_INC_PS / `CLK_PERIOD_PS
) (
    input wire ref_clk_i,
    input wire reset_i,
    // Command port from the bus transport, on this clock.
    input wire [7:0] cmd_code_i,
    input wire cmd_write_i,
    input wire cmd_read_i,
    input wire [15:0] cmd_wdata_i,
    input wire factory_load_i,
    output reg [15:0] cmd_rdata_o,
    output reg cmd_rvalid_o,
    output reg cmd_hit_o,
    // Power-stage side.
    input wire power_save_pin_i,
    input wire soft_start_done_i,
    input wire [VW-1:0] vout_target_i,
    input wire total_oc_limit_i,
    input wire [2:0] comp_ramp_code_i,
    output wire [VW-1:0] vout_applied_o,
    output wire slewing_o,
    output reg low_power_o,
    output wire master_phase_enable_o,
    output reg slave_phase_enable_o,
    output reg hiccup_adjustable_o,
    output reg sink_enable_o,
    output reg [3:0] ramp_amplitude_sel_o
);

    reg [3:0] vout_slew_step;
    reg bus_low_power_enable;
    reg pin_low_power_enable;
    reg adjustable_hiccup_select;
    reg sink_mode_disable;
    reg multi_phase;
    reg ps_meta;
    reg ps_sync;
    wire next_low_power;

    // Counter width for the slowest slew code at the default clock; a
    // longer period per step would need more bits here.
    localparam STEP_CW = 14;

    function is_mapped;
        input [7:0] code;
        begin
            is_mapped = (code == `CMD_VOUT_SLEW_STEP) ||
                        (code == `CMD_LOW_POWER_CONTROL) ||
                        (code == `CMD_MISC_FUNCTION_CONTROL);
        end
    endfunction

    // Builds the word a read returns; reserved bits are fixed at zero.
    function [15:0] read_word;
        input [7:0] code;
        begin
            case (code)
                `CMD_VOUT_SLEW_STEP: begin
                    read_word = {12'h000, vout_slew_step};
                end
                `CMD_LOW_POWER_CONTROL: begin
                    read_word = {14'h0, pin_low_power_enable,
                                 bus_low_power_enable};
                end
                `CMD_MISC_FUNCTION_CONTROL: begin
                    // Reserved fields read zero.
                    read_word = {5'h00, adjustable_hiccup_select,
                                 sink_mode_disable, 5'h00,
                                 multi_phase, 3'h0};
                end
                default: begin
                    read_word = 16'h0000;
                end
            endcase
        end
    endfunction

    // Save pin is asynchronous to this clock. Both stages reset high, the
    // pin's idle level, so leaving reset never looks like a save request.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ps_meta <= 1'b1;
            ps_sync <= 1'b1;
        end else begin
            ps_meta <= power_save_pin_i;
            ps_sync <= ps_meta;
        end
    end

    // Register writes. Only the documented field bits are stored, so
    // reserved bits cannot be set. Factory load wins over a write.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vout_slew_step <= `RST_VOUT_SLEW_STEP;
            {pin_low_power_enable, bus_low_power_enable} <=
                `RST_LOW_POWER_CONTROL;
            adjustable_hiccup_select <= `RST_ADJ_HICCUP_SELECT;
            sink_mode_disable <= `RST_SINK_MODE_DISABLE;
            multi_phase <= `RST_MULTI_PHASE;
        end else if (factory_load_i) begin
            vout_slew_step <= `RST_VOUT_SLEW_STEP;
            {pin_low_power_enable, bus_low_power_enable} <=
                `RST_LOW_POWER_CONTROL;
            adjustable_hiccup_select <= `RST_ADJ_HICCUP_SELECT;
            sink_mode_disable <= `RST_SINK_MODE_DISABLE;
            multi_phase <= `RST_MULTI_PHASE;
        end else if (cmd_write_i) begin
            case (cmd_code_i)
                `CMD_VOUT_SLEW_STEP: begin
                    vout_slew_step <= cmd_wdata_i[`SLEW_STEP_MSB:0];
                end
                `CMD_LOW_POWER_CONTROL: begin
                    bus_low_power_enable <= cmd_wdata_i[`LP_BUS_BIT];
                    pin_low_power_enable <= cmd_wdata_i[`LP_PIN_BIT];
                end
                `CMD_MISC_FUNCTION_CONTROL: begin
                    adjustable_hiccup_select <=
                        cmd_wdata_i[`MISC_ADJ_HICCUP_BIT];
                    sink_mode_disable <= cmd_wdata_i[`MISC_SINK_DISABLE_BIT];
                    multi_phase <= cmd_wdata_i[`MISC_MULTI_PHASE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data is registered one cycle after the strobe. Unmapped codes
    // answer zero with the hit flag low, so the transport can refuse them.
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmd_rdata_o <= 16'h0000;
            cmd_rvalid_o <= 1'b0;
            cmd_hit_o <= 1'b0;
        end else begin
            cmd_rvalid_o <= cmd_read_i;
            if (cmd_read_i) begin
                cmd_hit_o <= is_mapped(cmd_code_i);
                cmd_rdata_o <= read_word(cmd_code_i);
            end
        end
    end

    // Either path can request low power; the pin path counts only when
    // its enable bit is set, and the pin is active low.
    assign next_low_power = bus_low_power_enable |
                            (pin_low_power_enable & ~ps_sync);

    // The master phase has no gating term at all, by design.
    assign master_phase_enable_o = 1'b1;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_power_o <= 1'b0;
            slave_phase_enable_o <= 1'b1;
            hiccup_adjustable_o <= 1'b0;
            sink_enable_o <= 1'b1;
            ramp_amplitude_sel_o <= 4'h0;
        end else begin
            low_power_o <= next_low_power;
            slave_phase_enable_o <= ~next_low_power;
            // Otherwise hiccup time follows the soft-start time.
            hiccup_adjustable_o <= adjustable_hiccup_select &
                                   total_oc_limit_i;
            sink_enable_o <= ~sink_mode_disable;
            // Phase mode picks the ramp table bank.
            ramp_amplitude_sel_o <= {multi_phase, comp_ramp_code_i};
        end
    end

    vout_slew_stepper #(
        .VW(VW),
        .CW(STEP_CW),
        .BASE_CYCLES(STEP_BASE_CYCLES),
        .INC_CYCLES(STEP_INC_CYCLES)
    ) u_stepper (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .step_code_i(vout_slew_step),
        .soft_start_done_i(soft_start_done_i),
        .vout_target_i(vout_target_i),
        .vout_applied_o(vout_applied_o),
        .slewing_o(slewing_o)
    );

endmodule // converter_ctrl_regs

// ===== verification/converter_ctrl_regs_props.sv
// Checker for the converter control register bank, bound to its ports.
// Assumes single-cycle strobes and one clock domain.
`timescale 1ns/1ps
module converter_ctrl_regs_props #(
    parameter VW = 12,
    parameter STEP_BASE_CYCLES = 8,
    parameter STEP_INC_CYCLES = 2
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [7:0] cmd_code_i,
    input wire cmd_write_i,
    input wire cmd_read_i,
    input wire [15:0] cmd_wdata_i,
    input wire factory_load_i,
    input wire [15:0] cmd_rdata_o,
    input wire cmd_rvalid_o,
    input wire cmd_hit_o,
    input wire total_oc_limit_i,
    input wire [2:0] comp_ramp_code_i,
    input wire low_power_o,
    input wire master_phase_enable_o,
    input wire slave_phase_enable_o,
    input wire hiccup_adjustable_o,
    input wire sink_enable_o,
    input wire [3:0] ramp_amplitude_sel_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_wr(logic [7:0] c);
        cmd_write_i && !factory_load_i && cmd_code_i == c;
    endsequence
    AST_MASTER: assert property (master_phase_enable_o)
        else $error("master phase disabled");
    AST_SLAVE: assert property (slave_phase_enable_o == !low_power_o)
        else $error("slave enable does not follow low power");
    AST_BUS_LP: assert property (s_wr(8'he5) ##0 cmd_wdata_i[0]
        |-> ##2 low_power_o) else $error("bus low power not applied");
    AST_LP_OFF: assert property (s_wr(8'he5) ##0 !cmd_wdata_i[1]
        ##0 !cmd_wdata_i[0] |-> ##2 !low_power_o)
        else $error("low power without a source");
    AST_SINK: assert property (s_wr(8'hea)
        |-> ##2 sink_enable_o == !$past(cmd_wdata_i[9], 2))
        else $error("sink enable wrong");
    AST_HICCUP: assert property (hiccup_adjustable_o
        |-> $past(total_oc_limit_i)) else $error("hiccup without limit");
    AST_RAMP: assert property (!$past(reset_i)
        |-> ramp_amplitude_sel_o[2:0] == $past(comp_ramp_code_i))
        else $error("ramp code not passed on");
    AST_UNMAPPED: assert property (cmd_read_i &&
        !(cmd_code_i inside {8'hda, 8'he5, 8'hea}) |=> cmd_rvalid_o
        && !cmd_hit_o && cmd_rdata_o == 16'h0000)
        else $error("unmapped read answered");
endmodule // converter_ctrl_regs_props
bind converter_ctrl_regs converter_ctrl_regs_props #(.VW(VW),
    .STEP_BASE_CYCLES(STEP_BASE_CYCLES),
    .STEP_INC_CYCLES(STEP_INC_CYCLES)) converter_ctrl_regs_props_i (.*);

// ===== verification/pmbus_host_model.sv
// Host model that drives the command port of the register bank.
// Assumes requests launch 1 ns after a rising edge of ref_clk_i.
`timescale 1ns/1ps
module pmbus_host_model (
    input wire ref_clk_i,
    output logic [7:0] cmd_code_o,
    output logic cmd_write_o,
    output logic cmd_read_o,
    output logic [15:0] cmd_wdata_o,
    output logic factory_load_o,
    input wire [15:0] cmd_rdata_i,
    input wire cmd_rvalid_i,
    input wire cmd_hit_i
);
    initial begin
        {cmd_code_o, cmd_write_o, cmd_read_o} = 10'h0;
        {cmd_wdata_o, factory_load_o} = 17'h0;
    end
    // Released lines show the inverse so stale values never look valid.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge ref_clk_i);
        #1;
        {cmd_code_o, cmd_wdata_o, cmd_write_o} = {c, d, 1'b1};
        @(posedge ref_clk_i);
        #1;
        {cmd_code_o, cmd_wdata_o, cmd_write_o} = {~c, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d,
                      output logic h);
        @(posedge ref_clk_i);
        #1;
        {cmd_code_o, cmd_read_o} = {c, 1'b1};
        @(posedge ref_clk_i);
        #1;
        {cmd_code_o, cmd_read_o} = {~c, 1'b0};
        d = cmd_rvalid_i ? cmd_rdata_i : 16'hxxxx;
        h = cmd_rvalid_i ? cmd_hit_i : 1'bx;
    endtask
    task automatic load();
        @(posedge ref_clk_i);
        #1;
        factory_load_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        factory_load_o = 1'b0;
    endtask
endmodule // pmbus_host_model

// ===== verification/tb_converter_ctrl_regs.sv
// Self-checking bench for the converter control register bank.
// Assumes the host model owns the command port; the bench drives the rest.
`timescale 1ns/1ps
module tb_converter_ctrl_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] code;
    logic wr_s;
    logic rd_s;
    logic ld;
    logic [15:0] wd;
    logic [15:0] rdat;
    logic rv;
    logic hit;
    logic pin = 1'b1;
    logic ss = 1'b0;
    logic [11:0] tgt = 12'h000;
    logic oc = 1'b0;
    logic [2:0] rc = 3'h5;
    logic [11:0] app;
    logic lp;
    logic mst;
    logic slv;
    logic hic;
    logic snk;
    logic [3:0] rsel;
    logic slw;
    logic [15:0] got;
    logic gh;
    int num_errors = 0;
    int checks_done = 0;
    int g;
    always #2.5 clk = ~clk;
    pmbus_host_model pmbus_host_model_i (.ref_clk_i(clk), .cmd_code_o(code),
        .cmd_write_o(wr_s), .cmd_read_o(rd_s), .cmd_wdata_o(wd),
        .factory_load_o(ld), .cmd_rdata_i(rdat), .cmd_rvalid_i(rv),
        .cmd_hit_i(hit));
    converter_ctrl_regs #(.STEP_BASE_CYCLES(8), .STEP_INC_CYCLES(2))
        converter_ctrl_regs_i (.ref_clk_i(clk), .reset_i(rst),
        .cmd_code_i(code), .cmd_write_i(wr_s), .cmd_read_i(rd_s),
        .cmd_wdata_i(wd), .factory_load_i(ld), .cmd_rdata_o(rdat),
        .cmd_rvalid_o(rv), .cmd_hit_o(hit), .power_save_pin_i(pin),
        .soft_start_done_i(ss), .vout_target_i(tgt),
        .total_oc_limit_i(oc), .comp_ramp_code_i(rc),
        .vout_applied_o(app), .slewing_o(slw), .low_power_o(lp),
        .master_phase_enable_o(mst), .slave_phase_enable_o(slv),
        .hiccup_adjustable_o(hic), .sink_enable_o(snk),
        .ramp_amplitude_sel_o(rsel));
    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] v, input logic [15:0] e);
        checks_done++;
        if (v !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, v, e);
        end
    endtask
    task automatic chkb(input logic v, input logic e);
        chk({15'h0, v}, {15'h0, e});
    endtask
    task automatic rc_chk(input logic [7:0] c, input logic [15:0] e,
                          input logic h);
        pmbus_host_model_i.rd(c, got, gh);
        chk(got, e);
        chkb(gh, h);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Counts cycles until the applied code next moves, bounded.
    task automatic gap(output int n);
        logic [11:0] a;
        n = 0;
        a = app;
        while (app === a && n < 100) begin
            tick(1);
            n++;
        end
    endtask
    initial begin
        tick(3);
        rst = 1'b0;
        rc_chk(8'hda, 16'h0004, 1'b1);
        rc_chk(8'he5, 16'h0000, 1'b1);
        rc_chk(8'hea, 16'h0008, 1'b1);
        rc_chk(8'h5a, 16'h0000, 1'b0);
        pmbus_host_model_i.wr(8'hea, 16'hffff);
        oc = 1'b1;
        tick(2);
        rc_chk(8'hea, 16'h0608, 1'b1);
        chkb(snk, 1'b0);
        chkb(hic, 1'b1);
        chk({12'h000, rsel}, {12'h000, 1'b1, rc});
        oc = 1'b0;
        rc = 3'h2;
        tick(1);
        chkb(hic, 1'b0);
        chk({12'h000, rsel}, {12'h000, 1'b1, rc});
        pmbus_host_model_i.wr(8'hea, 16'h0000);
        tick(1);
        chk({12'h000, rsel}, {13'h0, rc});
        chkb(hic, 1'b0);
        chkb(snk, 1'b1);
        pmbus_host_model_i.wr(8'he5, 16'hfffd);
        tick(1);
        chkb(slv, 1'b0);
        chkb(mst, 1'b1);
        rc_chk(8'he5, 16'h0001, 1'b1);
        pmbus_host_model_i.wr(8'he5, 16'h0000);
        tick(1);
        chkb(lp, 1'b0);
        chkb(slv, 1'b1);
        pmbus_host_model_i.wr(8'he5, 16'h0002);
        tick(4);
        chkb(lp, 1'b0);
        pin = 1'b0;
        tick(3);
        chkb(lp, 1'b1);
        chkb(mst, 1'b1);
        pin = 1'b1;
        tick(3);
        chkb(slv, 1'b1);
        pin = 1'b0;
        pmbus_host_model_i.wr(8'he5, 16'h0001);
        pmbus_host_model_i.wr(8'hda, 16'h00ff);
        rc_chk(8'hda, 16'h000f, 1'b1);
        pmbus_host_model_i.load();
        tick(4);
        chkb(lp, 1'b0);
        rc_chk(8'hda, 16'h0004, 1'b1);
        rc_chk(8'hea, 16'h0008, 1'b1);
        pin = 1'b1;
        tgt = 12'h005;
        #1;
        chkb(slw, 1'b0);
        tick(2);
        chk({4'h0, app}, 16'h0005);
        ss = 1'b1;
        for (int c = 0; c < 16; c += 15) begin
            pmbus_host_model_i.wr(8'hda, 16'(c));
            tgt = app + 12'h004;
            gap(g);
            gap(g);
            chk(16'(g), 16'(8 + 2 * c));
            chkb(slw, 1'b1);
        end
        end_sim();
    end
    initial begin
        #20000;
        num_errors++;
        end_sim();
    end
endmodule // tb_converter_ctrl_regs
